//--- core/hscb_defs.svh
`ifndef HSCB_DEFS_SVH
`define HSCB_DEFS_SVH
// register byte offsets
`define HSCB_PROD_BASE 8'h54
`define HSCB_PROD_LAST 8'h91
`define HSCB_SER_BASE 8'h92
`define HSCB_SER_LAST 8'hcf
`define HSCB_CHG_OFS 8'hd0
`define HSCB_BOOST_OFS 8'hf6
`define HSCB_PLEN_OFS 8'h14
// field layout
`define HSCB_CHG_MASK 8'h1e
`define HSCB_BOOST_MASK 8'h03
`define HSCB_PLEN_MAX 8'h1f
// reset values
`define HSCB_CHG_RST 8'h00
`define HSCB_BOOST_RST 8'h00
`define HSCB_PLEN_RST 8'h00
`define HSCB_STR_RST 8'h00
`endif

//--- core/hscb_pkg.sv
package hscb_pkg;
    typedef enum logic [1:0] {
        HSCB_BOOST_NORMAL = 2'h0,
        HSCB_BOOST_LOW = 2'h1,
        HSCB_BOOST_MED = 2'h2,
        HSCB_BOOST_HIGH = 2'h3
    } hscb_boost_t;
endpackage

//--- core/hscb_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "hscb_defs.svh"
module hscb_regs #(
    parameter int STR_BYTES = 62
) (
    input wire logic mclk_i,                 // 125 MHz clock
    input wire logic nrst_i,                 // async reset, low
    input wire logic cfg_wr_i,               // config write strobe
    input wire logic [7:0] cfg_addr_i,       // config byte address
    input wire logic [7:0] cfg_wdata_i,      // config write data
    output logic [7:0] cfg_rdata_o,          // config read data
    input wire logic [4:0] prod_char_i,      // core product char index
    input wire logic [4:0] ser_char_i,       // core serial char index
    output logic [15:0] prod_char_o,         // product character
    output logic [15:0] ser_char_o,          // serial character
    output logic [4:0] product_text_length_o,// product length
    output logic [3:0] charging_port_enables_o, // ports 4..1
    output hscb_pkg::hscb_boost_t upstream_drive_level_field_o // boost
);
    import hscb_pkg::*;

    //----------------------------------------
    // state
    //----------------------------------------
    // one packed record keeps every flop under the single reset below
    typedef struct packed {
        logic [STR_BYTES-1:0][7:0] prod;
        logic [STR_BYTES-1:0][7:0] ser;
        logic [7:0] chg;
        logic [7:0] boost;
        logic [7:0] plen;
        logic [7:0] rdata;
        logic [15:0] pch;
        logic [15:0] sch;
    } hscb_state_t;

    hscb_state_t st_r;
    hscb_state_t st_nxt;
    logic [7:0] poff;
    logic [7:0] soff;
    logic [7:0] pidx;
    logic [7:0] sidx;

    //----------------------------------------
    // address decode
    //----------------------------------------
    // wraps below the base; the range tests keep such offsets unused
    assign poff = cfg_addr_i - `HSCB_PROD_BASE;
    assign soff = cfg_addr_i - `HSCB_SER_BASE;
    // character n at bytes 2n, 2n+1
    assign pidx = {2'h0, prod_char_i, 1'b0};
    assign sidx = {2'h0, ser_char_i, 1'b0};

    //----------------------------------------
    // next state
    //----------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (cfg_wr_i) begin
            if (cfg_addr_i >= `HSCB_PROD_BASE && cfg_addr_i <= `HSCB_PROD_LAST) begin
                st_nxt.prod[poff[5:0]] = cfg_wdata_i;
            end
            if (cfg_addr_i >= `HSCB_SER_BASE && cfg_addr_i <= `HSCB_SER_LAST) begin
                st_nxt.ser[soff[5:0]] = cfg_wdata_i;
            end
            if (cfg_addr_i == `HSCB_CHG_OFS) begin
                st_nxt.chg = cfg_wdata_i & `HSCB_CHG_MASK;
            end
            if (cfg_addr_i == `HSCB_BOOST_OFS) begin
                st_nxt.boost = cfg_wdata_i & `HSCB_BOOST_MASK;
            end
            // clamp, not wrap, so a long length never runs past the area
            // length saturates at 31
            if (cfg_addr_i == `HSCB_PLEN_OFS) begin
                st_nxt.plen = (cfg_wdata_i > `HSCB_PLEN_MAX) ? `HSCB_PLEN_MAX : cfg_wdata_i;
            end
        end
        // reads see the value before a same-cycle write
        // readback; unmapped reads zero
        if (cfg_addr_i >= `HSCB_PROD_BASE && cfg_addr_i <= `HSCB_PROD_LAST) begin
            st_nxt.rdata = st_r.prod[poff[5:0]];
        end else if (cfg_addr_i >= `HSCB_SER_BASE && cfg_addr_i <= `HSCB_SER_LAST) begin
            st_nxt.rdata = st_r.ser[soff[5:0]];
        end else if (cfg_addr_i == `HSCB_CHG_OFS) begin
            st_nxt.rdata = st_r.chg;
        end else if (cfg_addr_i == `HSCB_BOOST_OFS) begin
            st_nxt.rdata = st_r.boost;
        end else if (cfg_addr_i == `HSCB_PLEN_OFS) begin
            st_nxt.rdata = st_r.plen;
        end else begin
            st_nxt.rdata = 8'h00;
        end
        // index 31 has no bytes behind it, so it answers zero
        // high byte at next address
        if (prod_char_i < 5'h1f) begin
            st_nxt.pch = {st_r.prod[pidx[5:0] + 6'h01], st_r.prod[pidx[5:0]]};
        end else begin
            st_nxt.pch = 16'h0000;
        end
        if (ser_char_i < 5'h1f) begin
            st_nxt.sch = {st_r.ser[sidx[5:0] + 6'h01], st_r.ser[sidx[5:0]]};
        end else begin
            st_nxt.sch = 16'h0000;
        end
    end

    //----------------------------------------
    // state register
    //----------------------------------------
    // async clear; every field restarts at zero
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    //----------------------------------------
    // outputs
    //----------------------------------------
    // all outputs come straight from flops, no decode glitches
    assign cfg_rdata_o = st_r.rdata;
    assign prod_char_o = st_r.pch;
    assign ser_char_o = st_r.sch;
    assign product_text_length_o = st_r.plen[4:0];
    assign charging_port_enables_o = st_r.chg[4:1];
    assign upstream_drive_level_field_o = hscb_boost_t'(st_r.boost[1:0]);

    //----------------------------------------
    // checks
    //----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    //----------------------------------------
    // field write checks
    //----------------------------------------
    // reserved bits must never be stored

    AST_CHG_WRITE: assert property ((cfg_wr_i && cfg_addr_i == `HSCB_CHG_OFS) |=>
        charging_port_enables_o == $past(cfg_wdata_i[4:1])) else $error("charge enable not stored");
    AST_CHG_RSVD: assert property (st_r.chg[0] == 1'b0 && st_r.chg[7:5] == 3'h0)
        else $error("charge reserved bit set");
    AST_BOOST_WRITE: assert property ((cfg_wr_i && cfg_addr_i == `HSCB_BOOST_OFS) |=>
        upstream_drive_level_field_o == $past(cfg_wdata_i[1:0])) else $error("boost not stored");
    AST_BOOST_RSVD: assert property (st_r.boost[7:2] == 6'h00) else $error("boost reserved set");
    AST_PLEN_CAP: assert property (st_r.plen <= `HSCB_PLEN_MAX) else $error("length over 31");
    AST_PLEN_WRITE: assert property ((cfg_wr_i && cfg_addr_i == `HSCB_PLEN_OFS) |=>
        product_text_length_o == (($past(cfg_wdata_i) > `HSCB_PLEN_MAX) ? 5'h1f : $past(cfg_wdata_i[4:0])))
        else $error("length not stored or capped");

    //----------------------------------------
    // field hold checks
    //----------------------------------------
    // fields move only on a write to their own offset
    AST_CHG_HOLD: assert property (!(cfg_wr_i && cfg_addr_i == `HSCB_CHG_OFS) |=>
        $stable(charging_port_enables_o)) else $error("charge enables changed without write");
    AST_BOOST_HOLD: assert property (!(cfg_wr_i && cfg_addr_i == `HSCB_BOOST_OFS) |=>
        $stable(upstream_drive_level_field_o)) else $error("boost changed without write");
    AST_PLEN_HOLD: assert property (!(cfg_wr_i && cfg_addr_i == `HSCB_PLEN_OFS) |=>
        $stable(product_text_length_o)) else $error("length changed without write");

    //----------------------------------------
    // readback checks
    //----------------------------------------
    // a same-edge read returns the value before the write
    AST_CHG_RB_OLD: assert property ((cfg_wr_i && cfg_addr_i == `HSCB_CHG_OFS) |=>
        cfg_rdata_o == $past(st_r.chg)) else $error("charge readback not prior value");
    AST_BOOST_RB_OLD: assert property ((cfg_wr_i && cfg_addr_i == `HSCB_BOOST_OFS) |=>
        cfg_rdata_o == $past(st_r.boost)) else $error("boost readback not prior value");
    AST_PROD_RB: assert property ((cfg_wr_i && cfg_addr_i == `HSCB_PROD_BASE) ##1
        (!cfg_wr_i && cfg_addr_i == `HSCB_PROD_BASE) |=> cfg_rdata_o == $past(cfg_wdata_i, 2))
        else $error("product byte readback wrong");
    AST_SER_RB: assert property ((cfg_wr_i && cfg_addr_i == `HSCB_SER_LAST) ##1
        (!cfg_wr_i && cfg_addr_i == `HSCB_SER_LAST) |=> cfg_rdata_o == $past(cfg_wdata_i, 2))
        else $error("serial byte readback wrong");
    AST_BOOST_RB: assert property ((cfg_wr_i && cfg_addr_i == `HSCB_BOOST_OFS) ##1
        (!cfg_wr_i && cfg_addr_i == `HSCB_BOOST_OFS) |=> cfg_rdata_o == ($past(cfg_wdata_i, 2) & `HSCB_BOOST_MASK))
        else $error("boost readback wrong");

    //----------------------------------------
    // character and unmapped-read checks
    //----------------------------------------
    AST_CHAR_ORDER: assert property ((cfg_wr_i && cfg_addr_i == `HSCB_PROD_BASE) ##1
        (!cfg_wr_i && prod_char_i == 5'h00) |=> prod_char_o[7:0] == $past(cfg_wdata_i, 2))
        else $error("low byte not first");
    AST_SER_HIGH: assert property ((cfg_wr_i && cfg_addr_i == (`HSCB_SER_BASE + 8'h01)) ##1
        (!cfg_wr_i && ser_char_i == 5'h00) |=> ser_char_o[15:8] == $past(cfg_wdata_i, 2))
        else $error("serial high byte not second");
    AST_PROD_PAST_END: assert property (prod_char_i == 5'h1f |=> prod_char_o == 16'h0000)
        else $error("product index 31 not zero");
    AST_SER_PAST_END: assert property (ser_char_i == 5'h1f |=> ser_char_o == 16'h0000)
        else $error("serial index 31 not zero");
    AST_UNMAPPED: assert property ((cfg_addr_i == 8'hff) |=> cfg_rdata_o == 8'h00)
        else $error("unmapped read nonzero");

    //----------------------------------------
    // covers
    //----------------------------------------
    COV_PROD: cover property (cfg_wr_i && cfg_addr_i == `HSCB_PROD_LAST);
    COV_SER: cover property (cfg_wr_i && cfg_addr_i == `HSCB_SER_BASE);
    COV_BOOST_HI: cover property (upstream_drive_level_field_o == HSCB_BOOST_HIGH);
    COV_CHG_ALL: cover property (charging_port_enables_o == 4'hf);
    COV_PLEN_SAT: cover property (cfg_wr_i && cfg_addr_i == `HSCB_PLEN_OFS && cfg_wdata_i > `HSCB_PLEN_MAX);
endmodule // hscb_regs
`default_nettype wire

//--- bench/hscb_cfg_src.sv
`timescale 1ns/1ns
`default_nettype none
module hscb_cfg_src (
    input wire logic mclk_i,   // bench clock
    output logic wr_o,         // write strobe
    output logic [7:0] addr_o, // byte address
    output logic [7:0] wdat_o  // write data
);
    // bus idle and known until the first request
    initial begin
        wr_o = 1'b0;
        addr_o = 8'h00;
        wdat_o = 8'h00;
    end
    // low byte at base+2n, high at base+2n+1
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdat_o <= d;
    endtask
    task automatic idle(input logic [7:0] a);
        @(posedge mclk_i);
        wr_o <= 1'b0;
        addr_o <= a;
        wdat_o <= ~wdat_o;
    endtask
endmodule // hscb_cfg_src
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import hscb_pkg::*;
    logic mclk, nrst;
    logic [4:0] pix, six, plen;
    logic [7:0] rd_v, mem [256];
    logic [15:0] pch, sch;
    logic [3:0] chg;
    hscb_boost_t bst;
    wire logic wr;
    wire logic [7:0] adr, wd;
    int errors = 0, samples_checked = 0, seed = 32'h494d5867, i;
    hscb_cfg_src u_src (.mclk_i(mclk), .wr_o(wr), .addr_o(adr), .wdat_o(wd));
    hscb_regs u_dut (.mclk_i(mclk), .nrst_i(nrst), .cfg_wr_i(wr), .cfg_addr_i(adr), .cfg_wdata_i(wd),
        .cfg_rdata_o(rd_v), .prod_char_i(pix), .ser_char_i(six), .prod_char_o(pch), .ser_char_o(sch),
        .product_text_length_o(plen), .charging_port_enables_o(chg), .upstream_drive_level_field_o(bst));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
        u_src.put(a, d);
        if (a == 8'h14) mem[a] = (d > 8'h1f) ? 8'h1f : d;
        else if (a == 8'hd0) mem[a] = d & 8'h1e;
        else if (a == 8'hf6) mem[a] = d & 8'h03;
        else if (a >= 8'h54 && a <= 8'hcf) mem[a] = d;
    endtask
    task automatic rd_b(input logic [7:0] a);
        u_src.idle(a);
        @(posedge mclk);
        #1 chk("cfg_rdata", {8'h00, mem[a]}, {8'h00, rd_v});
    endtask
    task automatic results;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000 errors++;
        results;
    end
    initial begin
        nrst = 1'b0;
        pix = 5'h00;
        six = 5'h00;
        for (i = 0; i < 256; i++) mem[i] = 8'h00;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        #1 chk("reset_outputs", 16'h0000, {5'h00, plen, chg, bst});
        $display("test reset done");
        for (i = 8'h54; i <= 8'hcf; i++) wr_b(8'(i), 8'($random(seed)));
        wr_b(8'h54, 8'($random(seed)));
        rd_b(8'h54);
        wr_b(8'h93, 8'($random(seed)));
        rd_b(8'h93);
        wr_b(8'hcf, 8'($random(seed)));
        rd_b(8'hcf);
        for (i = 0; i < 256; i++) rd_b(8'(i));
        for (i = 0; i < 32; i++) begin
            @(posedge mclk);
            pix <= 5'(i);
            six <= 5'(i);
            @(posedge mclk);
            #1 chk("prod_char", i < 31 ? {mem[8'h55 + 2 * i], mem[8'h54 + 2 * i]} : 16'h0000, pch);
            chk("ser_char", i < 31 ? {mem[8'h93 + 2 * i], mem[8'h92 + 2 * i]} : 16'h0000, sch);
        end
        $display("test strings done");
        for (i = 0; i < 4; i++) begin
            wr_b(8'hf6, {6'($random(seed)), 2'(i)});
            wr_b(8'hd0, 8'($random(seed)));
            wr_b(8'h14, 8'(30 + i));
            wr_b(8'hf7, 8'($random(seed)));
            rd_b(8'hf6);
            chk("boost", {14'h0, mem[8'hf6][1:0]}, {14'h0, bst});
            chk("chg_en", {12'h0, mem[8'hd0][4:1]}, {12'h0, chg});
            chk("length", {11'h0, mem[8'h14][4:0]}, {11'h0, plen});
            rd_b(8'hd0);
            rd_b(8'h14);
            rd_b(8'hf7);
        end
        $display("test fields done");
        @(posedge mclk);
        nrst <= 1'b0;
        @(posedge mclk);
        #1 chk("reset_mid", 16'h0000, {5'h00, plen, chg, bst});
        for (i = 0; i < 256; i++) mem[i] = 8'h00;
        @(posedge mclk);
        nrst <= 1'b1;
        rd_b(8'hd0);
        $display("test mid reset done");
        wr_b(8'hf6, 8'h00);
        rd_b(8'hf6);
        chk("boost_default", 16'h0000, {14'h0, bst});
        $display("test boost default done");
        results;
    end
endmodule // tb_top
`default_nettype wire
